// file: testbench/iocd_link_src.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// far-side serial source
// ------------------------------------------------
module iocd_link_src (
	// frame control
	input  wire logic       send_en_in,
	input  wire logic [7:0] byte_in,
	// link pins
	output logic            hs_clk_out,
	output logic            ser_out
);
	// idle levels at time zero
	initial
	begin
		hs_clk_out = 1'b0;
		ser_out  = 1'b0;
	end
	// msb first, one bit per clock edge; clock stands still between frames
	always
	begin
		wait (send_en_in);
		while (send_en_in)
			for (int i = 7; i >= 0; i--)
			begin
				ser_out = byte_in[i];
				#31.25 hs_clk_out = ~hs_clk_out;
				#31.25;
			end
		ser_out = ~ser_out; // released: never leave the stale bit
	end
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  addr = 4'h0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  be = 4'h0;
	logic [31:0] rdata;
	logic        wreq;
	logic [3:0]  tb_pad = 4'h0;
	logic [3:0]  pad_d;
	logic [3:0]  oe_n;
	logic        ser_en = 1'b0;
	logic [7:0]  ser_byte = 8'h00;
	logic        hsc;
	logic        ser;
	logic [3:0]  od_r = 4'h0;
	logic [3:0]  od_f = 4'h0;
	logic [3:0]  tsc = 4'h0;
	logic        align = 1'b0;
	logic        sclk;
	logic [3:0]  byp;
	logic [3:0]  bypc;
	logic [3:0]  qr;
	logic [3:0]  qf;
	logic [7:0]  gw;
	logic [31:0] rv;
	logic [2:0]  s;
	logic [1:0]  seen;
	logic        found;
	int          n_mismatch = 0;
	int          cmp_count = 0;
	wire logic [3:0] pad_w;

	// bench owns pad 0 only while the serial source is released
	assign pad_w = {tb_pad[3:1], ser_en ? ser : tb_pad[0]};

	// 100 MHz system clock
	always #5 clk = ~clk;

	iocd_top dut (
		.clk_sys_in(clk), .reset_in(rst),
		.avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
		.avs_writedata_in(wdata), .avs_byteenable_in(be),
		.avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
		.pad_in(pad_w), .pad_data_out(pad_d), .pad_oe_n_out(oe_n),
		.edge_clock_hs_in({hsc, hsc}),
		.read_strobe_shifted_in(1'b0), .write_strobe_shifted_in(1'b0),
		.out_data_rise_in(od_r), .out_data_fall_in(od_f),
		.tristate_from_core_in(tsc), .word_align_req_in(align),
		.sclk_out(sclk), .bypass_input_out(byp),
		.bypass_clock_input_out(bypc), .in_data_rise_out(qr),
		.in_data_fall_out(qf), .gear_word_out(gw)
	);

	iocd_link_src src (
		.send_en_in(ser_en), .byte_in(ser_byte),
		.hs_clk_out(hsc), .ser_out(ser)
	);

	// ------------------------------------------------
	// shared tasks
	// ------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one avalon transfer; held until waitrequest is seen low
	task automatic av(input logic w, input logic [3:0] a,
		input logic [31:0] d, input logic [3:0] b);
		@(posedge clk);
		addr  <= a;
		wr    <= w;
		rd    <= !w;
		wdata <= d;
		be    <= b;
		do @(posedge clk); while (wreq !== 1'b0);
		rv = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic ctl(input logic [31:0] v);
		av(1'b1, iocd_pkg::ADDR_CTRL, v, 4'hf);
	endtask

	task automatic print_verdict;
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// hang guard: the tests need well under 10k cycles
	initial
	begin
		#200us;
		n_mismatch++;
		print_verdict();
	end

	// ------------------------------------------------
	// test sequence
	// ------------------------------------------------
	initial
	begin
		repeat (6) @(posedge clk);
		chk("waitreq_rst", 32'h1, {31'h0, wreq});
		chk("oe_n_rst", 32'hf, {28'h0, oe_n});
		rst <= 1'b0;
		av(1'b0, iocd_pkg::ADDR_CTRL, 32'h0, 4'hf);
		chk("ctrl_rst", iocd_pkg::CTRL_RESET, rv);
		av(1'b0, iocd_pkg::ADDR_DELAY, 32'h0, 4'hf);
		chk("delay_rst", 32'h0, rv);
		av(1'b0, 4'hc, 32'h0, 4'hf);
		chk("unmapped", 32'h0, rv);
		av(1'b1, iocd_pkg::ADDR_DELAY, 32'hffffffff, 4'hf);
		av(1'b0, iocd_pkg::ADDR_DELAY, 32'h0, 4'hf);
		chk("delay_sel", 32'h1f, rv);
		// every input, output and gearbox mode code once
		for (int i = 0; i < 4; i++)
		begin
			ctl(32'h25 * i);
			av(1'b0, iocd_pkg::ADDR_CTRL, 32'h0, 4'hf);
			chk("ctrl_modes", 32'h25 * i, rv);
		end
		ctl(32'h0);
		av(1'b0, iocd_pkg::ADDR_CTRL, 32'h0, 4'h0);
		ctl(32'h10);
		av(1'b1, iocd_pkg::ADDR_CTRL, 32'h7f, 4'h0);
		av(1'b0, iocd_pkg::ADDR_CTRL, 32'h0, 4'hf);
		chk("ctrl_no_bytes", 32'h10, rv);
		av(1'b1, iocd_pkg::ADDR_DELAY, 32'h0, 4'hf);
		$display("register test done");
		ctl(32'h0);
		tb_pad <= 4'ha;
		repeat (5) @(posedge clk);
		chk("bypass", 32'ha, {28'h0, byp});
		chk("bypass_clk", 32'ha, {28'h0, bypc});
		for (int m = 1; m < 3; m++)
		begin
			ctl(m);
			tb_pad <= 4'h5 + 4'(m);
			repeat (40) @(posedge clk);
			chk("in_rise", 32'h5 + m, {28'h0, qr});
			if (m == 2)
				chk("in_fall", 32'h7, {28'h0, qf});
		end
		$display("input test done");
		od_r <= 4'h9;
		od_f <= 4'h6;
		ctl(32'h0);
		repeat (40) @(posedge clk);
		chk("out_sdr", 32'h9, {28'h0, pad_d});
		chk("tri_sdr", 32'h0, {28'h0, oe_n});
		tsc <= 4'h5;
		ctl(32'h4);
		repeat (40) @(posedge clk);
		chk("out_latch", 32'h9, {28'h0, pad_d});
		chk("tri_sdr", 32'h5, {28'h0, oe_n});
		ctl(32'h8);
		repeat (20) @(posedge clk);
		seen = 2'b00;
		repeat (8)
		begin
			@(posedge clk);
			seen = seen | {pad_d === 4'h9, pad_d === 4'h6};
		end
		chk("out_ddr", 32'h3, {30'h0, seen});
		// the slow clock output must show both levels within a period
		seen = 2'b00;
		repeat (8)
		begin
			@(posedge clk);
			seen = seen | {sclk === 1'b1, sclk === 1'b0};
		end
		chk("sclk_toggle", 32'h3, {30'h0, seen});
		$display("output test done");
		// by-eight gearbox: step the boundary until the byte lines up
		ctl(32'h40);
		ser_byte <= 8'hb4;
		ser_en <= 1'b1;
		found = 1'b0;
		for (int i = 0; i < 9 && !found; i++)
		begin
			repeat (200) @(posedge clk);
			found = (gw === 8'hb4);
			if (!found)
			begin
				av(1'b0, iocd_pkg::ADDR_STATUS, 32'h0, 4'hf);
				s = rv[15:13];
				align <= 1'b1;
				repeat (2) @(posedge clk);
				align <= 1'b0;
				av(1'b0, iocd_pkg::ADDR_STATUS, 32'h0, 4'hf);
				chk("align_step", {29'h0, s + 3'h1}, {29'h0, rv[15:13]});
			end
		end
		chk("gear_word", 32'h1, {31'h0, found});
		ser_en <= 1'b0;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		chk("gear_rst", 32'h0, {24'h0, gw});
		rst <= 1'b0;
		av(1'b0, iocd_pkg::ADDR_STATUS, 32'h0, 4'hf);
		chk("align_rst", 32'h0, {29'h0, rv[15:13]});
		$display("gearbox test done");
		print_verdict();
	end
endmodule
`default_nettype wire

// file: verilog/iocd_pkg.sv
`default_nettype none
package iocd_pkg;

	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS     = 10;
	// silence on the read strobe that ends a read burst
	localparam int STROBE_QUIET_NS   = 200;
	localparam int STROBE_QUIET_CYC  =
		(STROBE_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCLK_HALF_DEFAULT = 4;
	localparam int FIXED_DELAY_DEF   = 4;

	// ------------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------------
	localparam int NUM_SLICES = 4;
	localparam int NUM_GEARS  = 2;
	localparam int WORD_W     = 8;
	localparam int SHIFT_W    = 16;
	localparam int HIST_W     = 64;

	// ------------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [3:0]  ADDR_CTRL    = 4'h0;
	localparam logic [3:0]  ADDR_DELAY   = 4'h4;
	localparam logic [3:0]  ADDR_STATUS  = 4'h8;
	localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
	localparam logic [4:0]  DELAY_RESET  = 5'h00;

	// ------------------------------------------------------------------
	// modes and types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {IN_BYPASS, IN_SDR, IN_DDR, IN_DDR_MEM}
		iocd_in_mode_t;
	typedef enum logic [1:0] {OUT_SDR_REG, OUT_SDR_LATCH, OUT_DDR,
		OUT_DDR_MEM} iocd_out_mode_t;
	typedef enum logic [1:0] {GEAR_OFF, GEAR_VIDEO7,
		GEAR_DESER_BY_EIGHT, GEAR_DESER_BY_FOUR} iocd_gear_mode_t;
	typedef enum logic [1:0] {EDGE_LEFT, EDGE_TOP, EDGE_BOTTOM, EDGE_RIGHT}
		iocd_edge_t;
	typedef enum logic {RS_QUIET, RS_BURST} iocd_rs_state_t;

	typedef struct packed {
		logic [22:0]     rsvd;
		logic            fixed_delay_en;
		logic            hs_sel;
		iocd_gear_mode_t gear_mode;
		logic            tri_ddr_mem;
		iocd_out_mode_t  out_mode;
		iocd_in_mode_t   in_mode;
	} iocd_ctrl_t;

	typedef struct packed {
		logic [12:0] rsvd;
		logic [2:0]  align_sel_c;
		logic [2:0]  align_sel_a;
		logic        sync_pol;
		logic [3:0]  pad_level;
		logic [7:0]  gear_word;
	} iocd_status_t;

endpackage
`default_nettype wire

// file: verilog/iocd_top.sv
`timescale 1ns/1ps
`default_nettype none
module iocd_top #(
	parameter iocd_pkg::iocd_edge_t EDGE = iocd_pkg::EDGE_BOTTOM,
	parameter int SCLK_HALF   = iocd_pkg::SCLK_HALF_DEFAULT,
	parameter int FIXED_DELAY = iocd_pkg::FIXED_DELAY_DEF
) (
	// clock and reset
	input  wire  logic        clk_sys_in,
	input  wire  logic        reset_in,
	// avalon-mm slave
	input  wire  logic [3:0]  avs_address_in,
	input  wire  logic        avs_read_in,
	input  wire  logic        avs_write_in,
	input  wire  logic [31:0] avs_writedata_in,
	input  wire  logic [3:0]  avs_byteenable_in,
	output logic       [31:0] avs_readdata_out,
	output logic              avs_waitrequest_out,
	// pads
	input  wire  logic [3:0]  pad_in,
	output logic       [3:0]  pad_data_out,
	output logic       [3:0]  pad_oe_n_out,
	// clocks from outside
	input  wire  logic [1:0]  edge_clock_hs_in,
	input  wire  logic        read_strobe_shifted_in,
	input  wire  logic        write_strobe_shifted_in,
	// core side
	input  wire  logic [3:0]  out_data_rise_in,
	input  wire  logic [3:0]  out_data_fall_in,
	input  wire  logic [3:0]  tristate_from_core_in,
	input  wire  logic        word_align_req_in,
	output logic              sclk_out,
	output logic       [3:0]  bypass_input_out,
	output logic       [3:0]  bypass_clock_input_out,
	output logic       [3:0]  in_data_rise_out,
	output logic       [3:0]  in_data_fall_out,
	output logic       [7:0]  gear_word_out
);
	localparam int NS = iocd_pkg::NUM_SLICES;
	localparam bit IS_RIGHT  = (EDGE == iocd_pkg::EDGE_RIGHT);
	localparam bit IS_BOTTOM = (EDGE == iocd_pkg::EDGE_BOTTOM);

	function automatic logic [3:0] ratio_of(iocd_pkg::iocd_gear_mode_t m);
		unique case (m)
			iocd_pkg::GEAR_VIDEO7:        ratio_of = 4'h7;
			iocd_pkg::GEAR_DESER_BY_FOUR: ratio_of = 4'h4;
			iocd_pkg::GEAR_OFF,
			iocd_pkg::GEAR_DESER_BY_EIGHT: ratio_of = 4'h8;
		endcase
	endfunction

	function automatic logic [7:0] window(logic [15:0] s, logic [2:0] off,
		logic [3:0] r);
		logic [15:0] t;
		t = s >> off;
		window = t[7:0] & ((8'h01 << r) - 8'h01);
	endfunction

	iocd_pkg::iocd_ctrl_t   ctrl;
	logic [4:0]             dynamic_delay_sel;
	iocd_pkg::iocd_status_t status;
	logic [3:0]  pad_m, pad_s;
	logic [1:0]  hs_m, hs_s;
	logic        hs_d, rs_m, rs_s, rs_d, ws_m, ws_s, ws_d;
	logic        hs_edge, rs_rise, rs_fall, ws_rise;
	logic [31:0] div_cnt;
	logic        sclk_level, sclk_rise, sclk_fall;
	logic [iocd_pkg::HIST_W-1:0] hist [NS];
	logic [NS-1:0] delayed;
	logic [5:0]    delay_idx;
	logic [NS-1:0] mem_r, mem_f, sync_r, sync_f;
	logic [NS-1:0] o0, o1a, o1, lat, ts0, ts1;
	iocd_pkg::iocd_rs_state_t rs_state;
	logic [31:0] quiet_cnt;
	logic        sync_clock_polarity;
	logic        align_req_q, align_req_d;
	logic [15:0] shift  [2];
	logic [3:0]  bitcnt [2];
	logic [2:0]  align_select [2];
	logic [1:0]  align_update;
	logic [7:0]  aligned [2];
	logic [1:0]  gear_on;
	logic [3:0]  ratio;
	logic [1:0]  ser;

	// ------------------------------------------------------------------
	// register bus
	// ------------------------------------------------------------------
	// one wait state: waitrequest drops in the cycle after the request
	always_ff @(posedge clk_sys_in or posedge reset_in)
		if (reset_in)
			avs_waitrequest_out <= 1'b1;
		else if (!avs_waitrequest_out)
			avs_waitrequest_out <= 1'b1;
		else if (avs_read_in || avs_write_in)
			avs_waitrequest_out <= 1'b0;

	// writes land at the edge where waitrequest is seen low
	always_ff @(posedge clk_sys_in or posedge reset_in)
		if (reset_in)
		begin
			ctrl              <= iocd_pkg::CTRL_RESET;
			dynamic_delay_sel <= iocd_pkg::DELAY_RESET;
		end
		else if (avs_write_in && !avs_waitrequest_out)
		begin
			for (int b = 0; b < 4; b++)
				if (avs_byteenable_in[b] && avs_address_in == iocd_pkg::ADDR_CTRL)
					ctrl[8*b +: 8] <= avs_writedata_in[8*b +: 8];
			if (avs_byteenable_in[0] && avs_address_in == iocd_pkg::ADDR_DELAY)
				dynamic_delay_sel <= avs_writedata_in[4:0];
			ctrl.rsvd <= '0;
		end

	always_comb
	begin
		status             = '0;
		status.gear_word   = gear_word_out;
		status.pad_level   = pad_s;
		status.sync_pol    = sync_clock_polarity;
		status.align_sel_a = align_select[0];
		status.align_sel_c = align_select[1];
	end

	// read data is loaded with the wait state so it stands at the release
	always_ff @(posedge clk_sys_in or posedge reset_in)
		if (reset_in)
			avs_readdata_out <= 32'h0000_0000;
		else if (avs_read_in && avs_waitrequest_out)
			unique case (avs_address_in)
				iocd_pkg::ADDR_CTRL:   avs_readdata_out <= ctrl;
				iocd_pkg::ADDR_DELAY:  avs_readdata_out <= {27'h0, dynamic_delay_sel};
				iocd_pkg::ADDR_STATUS: avs_readdata_out <= status;
				default:               avs_readdata_out <= 32'h0000_0000;
			endcase

	// ------------------------------------------------------------------
	// synchronisers and edge finders
	// ------------------------------------------------------------------
	// every outside level passes two flops; edges come from the second
	always_ff @(posedge clk_sys_in or posedge reset_in)
		if (reset_in)
		begin
			{pad_m, pad_s}   <= '0;
			{hs_m, hs_s} <= '0;
			{rs_m, rs_s, ws_m, ws_s} <= '0;
			{hs_d, rs_d, ws_d}     <= '0;
		end
		else
		begin
			pad_m  <= pad_in;
			pad_s  <= pad_m;
			hs_m   <= edge_clock_hs_in;
			hs_s   <= hs_m;
			hs_d   <= hs_s[ctrl.hs_sel];
			rs_m   <= read_strobe_shifted_in;
			rs_s   <= rs_m;
			rs_d   <= rs_s;
			ws_m   <= write_strobe_shifted_in;
			ws_s   <= ws_m;
			ws_d   <= ws_s;
		end

	assign hs_edge   = hs_s[ctrl.hs_sel] ^ hs_d;
	assign rs_rise   = IS_RIGHT && rs_s && !rs_d;
	assign rs_fall   = IS_RIGHT && !rs_s && rs_d;
	assign ws_rise   = IS_RIGHT && ws_s && !ws_d;

	// ------------------------------------------------------------------
	// system clock phase
	// ------------------------------------------------------------------
	// the slow system clock is a phase with rise/fall enable pulses
	always_ff @(posedge clk_sys_in or posedge reset_in)
		if (reset_in)
		begin
			div_cnt    <= '0;
			sclk_level <= 1'b0;
			sclk_rise  <= 1'b0;
			sclk_fall  <= 1'b0;
		end
		else if (div_cnt == 32'(SCLK_HALF - 1))
		begin
			div_cnt    <= '0;
			sclk_level <= ~sclk_level;
			sclk_rise  <= ~sclk_level;
			sclk_fall  <= sclk_level;
		end
		else
		begin
			div_cnt   <= div_cnt + 32'h1;
			sclk_rise <= 1'b0;
			sclk_fall <= 1'b0;
		end

	always_ff @(posedge clk_sys_in or posedge reset_in)
		if (reset_in)
			sclk_out <= 1'b0;
		else
			sclk_out <= sclk_level;

	// ------------------------------------------------------------------
	// input delay and bypass
	// ------------------------------------------------------------------
	// delay is a tap on a history of sampled pad levels
	assign delay_idx = (ctrl.fixed_delay_en ? 6'(FIXED_DELAY) : 6'h00)
		+ (IS_BOTTOM ? {1'b0, dynamic_delay_sel} : 6'h00);

	generate
		for (genvar i = 0; i < NS; i++)
		begin : g_slice
			always_ff @(posedge clk_sys_in or posedge reset_in)
				if (reset_in)
					hist[i] <= '0;
				else
					hist[i] <= {hist[i][iocd_pkg::HIST_W-2:0], pad_s[i]};
			assign delayed[i] = (delay_idx == 6'h00) ? pad_s[i]
				: hist[i][delay_idx - 6'h01];
		end
	endgenerate

	// bypass skips delay and registers (one flop to meet output style)
	always_ff @(posedge clk_sys_in or posedge reset_in)
		if (reset_in)
		begin
			bypass_input_out       <= '0;
			bypass_clock_input_out <= '0;
		end
		else
		begin
			bypass_input_out       <= pad_s;
			bypass_clock_input_out <= pad_s;
		end

	// ------------------------------------------------------------------
	// input registers
	// ------------------------------------------------------------------
	// strobe-domain capture for memory reads
	always_ff @(posedge clk_sys_in or posedge reset_in)
		if (reset_in)
			{mem_r, mem_f} <= '0;
		else
		begin
			if (rs_rise)
				mem_r <= delayed;
			if (rs_fall)
				mem_f <= delayed;
		end

	// resync edge chosen by polarity to keep clear of the strobe edge
	always_ff @(posedge clk_sys_in or posedge reset_in)
		if (reset_in)
			{sync_r, sync_f} <= '0;
		else if (sync_clock_polarity ? sclk_fall : sclk_rise)
		begin
			sync_r <= mem_r;
			sync_f <= mem_f;
		end

	always_ff @(posedge clk_sys_in or posedge reset_in)
		if (reset_in)
			{in_data_rise_out, in_data_fall_out} <= '0;
		else
			unique case (ctrl.in_mode)
				iocd_pkg::IN_BYPASS: ;
				iocd_pkg::IN_SDR:
					if (sclk_rise)
						in_data_rise_out <= delayed;
				iocd_pkg::IN_DDR:
				begin
					if (sclk_rise)
						in_data_rise_out <= delayed;
					if (sclk_fall)
						in_data_fall_out <= delayed;
				end
				iocd_pkg::IN_DDR_MEM:
					if (IS_RIGHT && sclk_rise)
					begin
						in_data_rise_out <= sync_r;
						in_data_fall_out <= sync_f;
					end
			endcase

	// polarity is sampled afresh at the first strobe rise of each read
	always_ff @(posedge clk_sys_in or posedge reset_in)
		if (reset_in)
		begin
			rs_state            <= iocd_pkg::RS_QUIET;
			quiet_cnt           <= '0;
			sync_clock_polarity <= 1'b0;
		end
		else if (IS_RIGHT)
		begin
			quiet_cnt <= (rs_rise || rs_fall) ? '0 : quiet_cnt + 32'h1;
			unique case (rs_state)
				iocd_pkg::RS_QUIET:
					if (rs_rise)
					begin
						sync_clock_polarity <= sclk_level;
						rs_state            <= iocd_pkg::RS_BURST;
					end
				iocd_pkg::RS_BURST:
					if (quiet_cnt >= 32'(iocd_pkg::STROBE_QUIET_CYC))
						rs_state <= iocd_pkg::RS_QUIET;
			endcase
		end

	// ------------------------------------------------------------------
	// output and tristate registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys_in or posedge reset_in)
		if (reset_in)
			{o0, o1a, o1, ts0} <= '0;
		else
		begin
			if (sclk_rise)
			begin
				o0  <= out_data_rise_in;
				o1a <= out_data_fall_in;
				ts0 <= tristate_from_core_in;
			end
			if (sclk_fall)
				o1 <= o1a;
		end

	// latch is transparent while the system clock is high
	always_ff @(posedge clk_sys_in or posedge reset_in)
		if (reset_in)
			lat <= '0;
		else if (sclk_level)
			lat <= out_data_rise_in;

	always_ff @(posedge clk_sys_in or posedge reset_in)
		if (reset_in)
			ts1 <= '0;
		else if (ws_rise)
			ts1 <= ts0;

	// pad drive; output enable is low while driving
	always_ff @(posedge clk_sys_in or posedge reset_in)
		if (reset_in)
		begin
			pad_data_out <= '0;
			pad_oe_n_out <= '1;
		end
		else
		begin
			unique case (ctrl.out_mode)
				iocd_pkg::OUT_SDR_REG:   pad_data_out <= o0;
				iocd_pkg::OUT_SDR_LATCH: pad_data_out <= lat;
				iocd_pkg::OUT_DDR:
					pad_data_out <= sclk_level ? o0 : o1;
				iocd_pkg::OUT_DDR_MEM:
					pad_data_out <= (!IS_RIGHT || ws_s) ? o0 : o1;
			endcase
			pad_oe_n_out <= (IS_RIGHT && ctrl.tri_ddr_mem) ? ts1 : ts0;
		end

	// ------------------------------------------------------------------
	// input gearbox
	// ------------------------------------------------------------------
	assign ratio   = ratio_of(ctrl.gear_mode);
	assign gear_on = {ctrl.gear_mode == iocd_pkg::GEAR_DESER_BY_FOUR,
		ctrl.gear_mode != iocd_pkg::GEAR_OFF};
	assign ser     = {delayed[2], delayed[0]};

	// align requests act on their registered rising edge
	always_ff @(posedge clk_sys_in or posedge reset_in)
		if (reset_in)
			{align_req_q, align_req_d} <= '0;
		else
		begin
			align_req_q <= word_align_req_in;
			align_req_d <= align_req_q;
		end

	generate
		for (genvar g = 0; g < iocd_pkg::NUM_GEARS; g++)
		begin : g_gear
			// stage one: a bit on each edge of the edge clock
			always_ff @(posedge clk_sys_in or posedge reset_in)
				if (reset_in)
				begin
					shift[g]        <= '0;
					bitcnt[g]       <= '0;
					align_update[g] <= 1'b0;
				end
				else if (gear_on[g] && hs_edge)
				begin
					shift[g] <= {shift[g][14:0], ser[g]};
					align_update[g] <= (bitcnt[g] == ratio - 4'h1);
					bitcnt[g] <= (bitcnt[g] == ratio - 4'h1) ? 4'h0
						: bitcnt[g] + 4'h1;
				end
				else
					align_update[g] <= 1'b0;

			// boundary moves one bit per request, wrapping at the ratio
			always_ff @(posedge clk_sys_in or posedge reset_in)
				if (reset_in)
					align_select[g] <= '0;
				else if (!gear_on[g])
					align_select[g] <= '0;
				else if (align_req_q && !align_req_d)
					align_select[g] <= ({1'b0, align_select[g]} ==
						ratio - 4'h1) ? 3'h0 : align_select[g] + 3'h1;

			// stage two: realign the completed word
			always_ff @(posedge clk_sys_in or posedge reset_in)
				if (reset_in)
					aligned[g] <= '0;
				else if (align_update[g])
					aligned[g] <= window(shift[g], align_select[g],
						ratio);
		end
	endgenerate

	// stage three: word to core on the system clock rise
	always_ff @(posedge clk_sys_in or posedge reset_in)
		if (reset_in)
			gear_word_out <= '0;
		else if (sclk_rise)
			unique case (ctrl.gear_mode)
				iocd_pkg::GEAR_OFF:            gear_word_out <= 8'h00;
				iocd_pkg::GEAR_VIDEO7:
					gear_word_out <= {1'b0, aligned[0][6:0]};
				iocd_pkg::GEAR_DESER_BY_EIGHT: gear_word_out <= aligned[0];
				iocd_pkg::GEAR_DESER_BY_FOUR:
					gear_word_out <= {aligned[0][3:0], aligned[1][3:0]};
			endcase

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	a_bypass_path: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		1'b1 |=> bypass_input_out == $past(pad_s))
		else $error("bypass output does not follow pad");
	a_sdr_capture: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		(ctrl.in_mode == iocd_pkg::IN_SDR && sclk_rise)
		|=> in_data_rise_out == $past(delayed))
		else $error("sdr input not captured on rise");
	a_ddr_fall_in: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		(ctrl.in_mode == iocd_pkg::IN_DDR && sclk_fall && $stable(ctrl))
		|=> in_data_fall_out == $past(delayed))
		else $error("ddr input not captured on fall");
	a_fall_refile: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		sclk_rise ##[1:16] sclk_fall |=> o1 == $past(o1a))
		else $error("fall data not refiled on fall");
	a_ddr_out_mux: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		(ctrl.out_mode == iocd_pkg::OUT_DDR && !sclk_level && $stable(ctrl))
		|=> pad_data_out == $past(o1))
		else $error("ddr output mux wrong in low phase");
	// the edge that releases reset still loads the reset value, so skip it
	a_tri_sdr_path: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		(!ctrl.tri_ddr_mem && $stable(ctrl) && !$past(reset_in))
		|=> pad_oe_n_out == $past(ts0))
		else $error("tristate not from sdr register");
	a_align_wrap: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		(gear_on[0] && align_req_q && !align_req_d && $stable(ctrl)
		&& {1'b0, align_select[0]} == ratio - 4'h1)
		|=> align_select[0] == 3'h0)
		else $error("align select failed to wrap");
	a_word_stage3: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		(ctrl.gear_mode == iocd_pkg::GEAR_DESER_BY_EIGHT && sclk_rise)
		|=> gear_word_out == $past(aligned[0]))
		else $error("gearbox word not passed on rise");
	a_update_period: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		(align_update[0] && ctrl.gear_mode == iocd_pkg::GEAR_DESER_BY_EIGHT)
		|=> !align_update[0] [*8])
		else $error("update pulses closer than a word");

endmodule
`default_nettype wire
